// File: logic/clock_ctrl_pkg.sv
// Purpose: Shared constants and types of the clock source and gating control.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes:   Clock domains are carried as one-cycle enable pulses on clock.
// ============================================================================
// Package
package clock_ctrl_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFF_PERIPH_ENABLE   = 8'h10;
  localparam logic [7:0] OFF_PERIPH_DISABLE  = 8'h14;
  localparam logic [7:0] OFF_PERIPH_STATUS   = 8'h18;
  localparam logic [7:0] OFF_MAIN_OSC_CTRL   = 8'h20;
  localparam logic [7:0] OFF_MAIN_CLK_FREQ   = 8'h24;
  localparam logic [7:0] OFF_PLL_CONFIG      = 8'h2C;
  localparam logic [7:0] OFF_MASTER_CLK_CFG  = 8'h30;
  localparam logic [7:0] OFF_PROG_CLK_CFG0   = 8'h40;
  localparam logic [7:0] OFF_PROG_CLK_CFG1   = 8'h44;
  localparam logic [7:0] OFF_PROG_CLK_CFG2   = 8'h48;
  localparam logic [7:0] OFF_CLOCK_STATUS    = 8'h68;

  // ==========================================================================
  // Field positions
  localparam int POS_OSC_ENABLE    = 0;
  localparam int POS_OSC_BYPASS    = 1;
  localparam int POS_OSC_COUNT     = 8;
  localparam int POS_FREQ_VALID    = 16;
  localparam int POS_PLL_REF_DIV   = 0;
  localparam int POS_PLL_SETTLE    = 8;
  localparam int POS_PLL_RANGE     = 14;
  localparam int POS_PLL_MULT      = 16;
  localparam int POS_USB_RATIO     = 28;
  localparam int POS_CLK_SRC       = 0;
  localparam int POS_CLK_RATIO     = 2;
  localparam int POS_SR_OSC_STABLE = 0;
  localparam int POS_SR_PLL_LOCK   = 2;
  localparam int POS_SR_MCK_READY  = 3;
  localparam int POS_SR_PCK_READY  = 8;
  localparam int FIRST_PERIPH_BIT  = 2;

  // ==========================================================================
  // Reset values and counts
  localparam logic [31:0] RST_PLL_CONFIG   = 32'h0000_3F00;
  localparam logic [4:0]  RST_CLK_CFG      = 5'h00;
  localparam int          OSC_COUNT_SCALE  = 8;
  localparam int          FREQ_WINDOW      = 16;
  localparam int          NUM_PROG_CLOCKS  = 3;
  localparam int          NUM_CLK_CHANNELS = 4;

  // ==========================================================================
  // Encodings
  typedef enum logic [1:0] {
    SRC_SLOW     = 2'b00,
    SRC_MAIN     = 2'b01,
    SRC_RESERVED = 2'b10,
    SRC_PLL      = 2'b11
  } clk_src_t;

  localparam logic [2:0] RATIO_RESERVED = 3'b111;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pll_enable;
    logic [10:0] pll_multiplier;
    logic [1:0]  pll_range;
    logic        pll_ref_tick;
  } pll_ctrl_t;

endpackage : clock_ctrl_pkg

// File: logic/clock_source_and_gating_control.sv
// Purpose: Clock gating, oscillator, PLL and clock selection control.
// Assumes: Slow, main and PLL clocks arrive as enable pulses on clock.
// Notes:   Analog oscillator and PLL are outside; this block steers them.
// ============================================================================
// Overview of operation
// - Writing one to a disable bit stops that peripheral clock; zero no effect.
// - Status shows running peripheral clocks in bits 2..31; bits 0,1 read zero.
// - Oscillator control bit 0 enables the main oscillator; keep bypass zero.
// - Without bypass, stable flag rises only after the programmed start-up time elapsed.
// - Bypass bit routes external clock and sets stable flag at once.
// - Enable and bypass both zero clears the stable flag.
// - Start-up wait is field bits 15:8 times eight slow-clock cycles.
// - Frequency field counts main-clock cycles in 16 slow-clock periods.
// - Frequency valid bit is one only after enable or bypass and a finished count.
// - PLL input divider: 0 no output, 1 pass, 2..255 divide by value.
// - Any PLL write restarts lock: wait settle count slow cycles, then lock.
// - Multiplier zero turns PLL off; else output is input times value+1.
// - USB ratio 00 passes, 01 halves, 10 quarters PLL clock; 11 reserved.
// - Master source: 00 slow, 01 main, 11 PLL; 10 reserved.
// - Master prescaler codes 000..110 divide by 1..64; 111 reserved.
// - Each programmable clock has its own source field, same encoding.
// - Each programmable clock has its own power-of-two prescaler 1..64.
// - Status register shows PLL lock flag.
// - Status register shows a ready flag per programmable clock.
// - Status register shows master clock ready flag.
`timescale 1ns/10ps

module clock_source_and_gating_control
  import clock_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        rst,
  // Register bus
  input  wire apb_req_t                    apb_req,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Clock sources as enable pulses
  input  wire logic                        slow_tick,
  input  wire logic                        main_tick,
  input  wire logic                        pll_tick,
  // Oscillator and PLL control
  output logic                             osc_enable,
  output logic                             osc_bypass,
  output pll_ctrl_t                        pll_ctrl,
  // Generated clocks
  output logic                             usb_tick,
  output logic                             master_tick,
  output logic [NUM_PROG_CLOCKS-1:0]       prog_tick,
  output logic [31:0]                      periph_clock_en
);

  // ==========================================================================
  // Helpers
  function automatic logic pick_src(input logic [1:0] src,
                                    input logic       s_slow,
                                    input logic       s_main,
                                    input logic       s_pll);
    logic r;
    r = 1'b0;
    unique case (clk_src_t'(src))
      SRC_SLOW:     r = s_slow;
      SRC_MAIN:     r = s_main;
      SRC_PLL:      r = s_pll;
      SRC_RESERVED: r = 1'b0;
    endcase
    return r;
  endfunction : pick_src

  function automatic logic [5:0] ratio_last(input logic [2:0] ratio);
    logic [6:0] d;
    d = 7'h01 << ratio;
    return 6'(d - 7'h01);
  endfunction : ratio_last

  // ==========================================================================
  // Register bus access
  logic        wr_en;
  logic        setup;
  logic [31:0] wdata;
  logic [7:0]  addr;

  assign setup  = apb_req.psel & ~apb_req.penable;
  assign wr_en  = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign wdata  = apb_req.pwdata;
  assign addr   = apb_req.paddr;
  assign pready = 1'b1;

  // ==========================================================================
  // Peripheral clock gating
  logic [31:0] periph_on_r;
  logic [31:0] periph_mask;

  assign periph_mask = {{(32-FIRST_PERIPH_BIT){1'b1}},
                        {FIRST_PERIPH_BIT{1'b0}}};

  always_ff @(posedge clock) begin
    if (rst) begin
      periph_on_r <= 32'h0000_0000;
    end else if (wr_en && addr == OFF_PERIPH_ENABLE) begin
      periph_on_r <= periph_on_r | (wdata & periph_mask);
    end else if (wr_en && addr == OFF_PERIPH_DISABLE) begin
      periph_on_r <= periph_on_r & ~(wdata & periph_mask);
    end
  end

  assign periph_clock_en = periph_on_r;

  // ==========================================================================
  // Main oscillator control and start-up
  logic        main_osc_enable_r;
  logic        osc_bypass_a_r;
  logic [7:0]  osc_startup_count_r;
  logic [10:0] startup_left_r;
  logic        main_osc_stable_r;
  logic        osc_mor_wr;
  logic        main_clk;

  assign osc_mor_wr = wr_en && addr == OFF_MAIN_OSC_CTRL;
  assign main_clk   = main_tick & (main_osc_enable_r | osc_bypass_a_r);

  always_ff @(posedge clock) begin
    if (rst) begin
      main_osc_enable_r   <= 1'b0;
      osc_bypass_a_r      <= 1'b0;
      osc_startup_count_r <= 8'h00;
    end else if (osc_mor_wr) begin
      main_osc_enable_r   <= wdata[POS_OSC_ENABLE];
      osc_bypass_a_r      <= wdata[POS_OSC_BYPASS];
      osc_startup_count_r <= wdata[POS_OSC_COUNT +: 8];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      startup_left_r    <= 11'h000;
      main_osc_stable_r <= 1'b0;
    end else if (osc_mor_wr && wdata[POS_OSC_BYPASS]) begin
      main_osc_stable_r <= 1'b1;
    end else if (osc_mor_wr && !wdata[POS_OSC_ENABLE]) begin
      main_osc_stable_r <= 1'b0;
    end else if (osc_mor_wr && !main_osc_enable_r) begin
      startup_left_r    <= 11'(wdata[POS_OSC_COUNT +: 8] * OSC_COUNT_SCALE);
      main_osc_stable_r <= 1'b0;
    end else if (main_osc_enable_r && !main_osc_stable_r) begin
      if (startup_left_r == 11'h000) begin
        main_osc_stable_r <= 1'b1;
      end else if (slow_tick) begin
        startup_left_r <= startup_left_r - 11'h001;
      end
    end
  end

  assign osc_enable = main_osc_enable_r;
  assign osc_bypass = osc_bypass_a_r;

  // ==========================================================================
  // Main clock frequency measurement
  logic [15:0] main_freq_count_r;
  logic [15:0] freq_acc_r;
  logic [4:0]  window_r;
  logic        measuring_r;
  logic        main_freq_valid_r;
  logic        osc_on;

  assign osc_on = main_osc_enable_r | osc_bypass_a_r;

  always_ff @(posedge clock) begin
    if (rst || !osc_on) begin
      main_freq_count_r <= 16'h0000;
      freq_acc_r        <= 16'h0000;
      window_r          <= 5'h00;
      measuring_r       <= 1'b0;
      main_freq_valid_r <= 1'b0;
    end else if (!measuring_r) begin
      if (main_osc_stable_r && !main_freq_valid_r && slow_tick) begin
        measuring_r <= 1'b1;
        freq_acc_r  <= 16'h0000;
        window_r    <= 5'h00;
      end
    end else begin
      if (main_clk && freq_acc_r != 16'hFFFF) begin
        freq_acc_r <= freq_acc_r + 16'h0001;
      end
      if (slow_tick) begin
        window_r <= window_r + 5'h01;
        if (window_r == 5'(FREQ_WINDOW - 1)) begin
          measuring_r       <= 1'b0;
          main_freq_count_r <= freq_acc_r + 16'(main_clk);
          main_freq_valid_r <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // PLL configuration and lock
  logic [31:0] pll_cfg_r;
  logic [5:0]  settle_left_r;
  logic        pll_lock_r;
  logic [7:0]  ref_cnt_r;
  logic        ref_tick_r;
  logic        pll_clk;
  logic [1:0]  usb_cnt_r;
  logic        usb_tick_r;
  logic [7:0]  ref_div;
  logic [10:0] pll_multiplier;
  logic [1:0]  usb_clock_ratio;

  assign ref_div         = pll_cfg_r[POS_PLL_REF_DIV +: 8];
  assign pll_multiplier  = pll_cfg_r[POS_PLL_MULT +: 11];
  assign usb_clock_ratio = pll_cfg_r[POS_USB_RATIO +: 2];
  assign pll_clk         = pll_tick & (pll_multiplier != 11'h000);

  always_ff @(posedge clock) begin
    if (rst) begin
      pll_cfg_r <= RST_PLL_CONFIG;
    end else if (wr_en && addr == OFF_PLL_CONFIG) begin
      pll_cfg_r <= wdata & 32'h37FF_FFFF;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      settle_left_r <= RST_PLL_CONFIG[POS_PLL_SETTLE +: 6];
      pll_lock_r    <= 1'b0;
    end else if (wr_en && addr == OFF_PLL_CONFIG) begin
      settle_left_r <= wdata[POS_PLL_SETTLE +: 6];
      pll_lock_r    <= 1'b0;
    end else if (!pll_lock_r) begin
      if (settle_left_r == 6'h00) begin
        pll_lock_r <= 1'b1;
      end else if (slow_tick) begin
        settle_left_r <= settle_left_r - 6'h01;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ref_cnt_r  <= 8'h00;
      ref_tick_r <= 1'b0;
    end else begin
      ref_tick_r <= 1'b0;
      if (ref_div == 8'h00) begin
        ref_cnt_r <= 8'h00;
      end else if (main_clk) begin
        if (ref_cnt_r >= ref_div - 8'h01) begin
          ref_cnt_r  <= 8'h00;
          ref_tick_r <= 1'b1;
        end else begin
          ref_cnt_r <= ref_cnt_r + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      usb_cnt_r  <= 2'b00;
      usb_tick_r <= 1'b0;
    end else begin
      usb_tick_r <= 1'b0;
      if (pll_clk && usb_clock_ratio != 2'b11) begin
        if (usb_cnt_r >= (2'b01 << usb_clock_ratio) - 2'b01 ||
            usb_clock_ratio == 2'b00) begin
          usb_cnt_r  <= 2'b00;
          usb_tick_r <= 1'b1;
        end else begin
          usb_cnt_r <= usb_cnt_r + 2'b01;
        end
      end
    end
  end

  assign usb_tick                = usb_tick_r;
  assign pll_ctrl.pll_enable     = pll_multiplier != 11'h000;
  assign pll_ctrl.pll_multiplier = pll_multiplier;
  assign pll_ctrl.pll_range      = pll_cfg_r[POS_PLL_RANGE +: 2];
  assign pll_ctrl.pll_ref_tick   = ref_tick_r;

  // ==========================================================================
  // Master and programmable clock generators
  logic [4:0] clk_cfg_r [NUM_CLK_CHANNELS];
  logic [4:0] clk_act_r [NUM_CLK_CHANNELS];
  logic [5:0] clk_cnt_r [NUM_CLK_CHANNELS];
  logic       clk_out_r [NUM_CLK_CHANNELS];
  logic       clk_rdy_r [NUM_CLK_CHANNELS];

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CLK_CHANNELS; ch++) begin : g_clk
      localparam logic [7:0] CH_OFF =
        (ch == 0) ? OFF_MASTER_CLK_CFG : 8'(OFF_PROG_CLK_CFG0 + 4 * (ch - 1));
      logic       src_pulse;
      logic [2:0] ratio;

      assign ratio     = clk_act_r[ch][POS_CLK_RATIO +: 3];
      assign src_pulse = pick_src(clk_act_r[ch][POS_CLK_SRC +: 2],
                                  slow_tick, main_clk, pll_clk);

      always_ff @(posedge clock) begin
        if (rst) begin
          clk_cfg_r[ch] <= RST_CLK_CFG;
        end else if (wr_en && addr == CH_OFF) begin
          clk_cfg_r[ch] <= wdata[4:0];
        end
      end

      always_ff @(posedge clock) begin
        if (rst) begin
          clk_act_r[ch] <= RST_CLK_CFG;
          clk_cnt_r[ch] <= 6'h00;
          clk_out_r[ch] <= 1'b0;
          clk_rdy_r[ch] <= (ch == 0);
        end else begin
          clk_out_r[ch] <= 1'b0;
          if (clk_cfg_r[ch] != clk_act_r[ch]) begin
            clk_rdy_r[ch] <= 1'b0;
          end
          if (clk_cfg_r[ch] != clk_act_r[ch] && clk_cnt_r[ch] == 6'h00) begin
            clk_act_r[ch] <= clk_cfg_r[ch];
            clk_rdy_r[ch] <= 1'b1;
          end else if (src_pulse && ratio != RATIO_RESERVED) begin
            if (clk_cnt_r[ch] == ratio_last(ratio)) begin
              clk_cnt_r[ch] <= 6'h00;
              clk_out_r[ch] <= 1'b1;
            end else begin
              clk_cnt_r[ch] <= clk_cnt_r[ch] + 6'h01;
            end
          end
        end
      end
    end
  endgenerate

  assign master_tick = clk_out_r[0];
  assign prog_tick   = {clk_out_r[3], clk_out_r[2], clk_out_r[1]};

  // ==========================================================================
  // Read data and status
  logic [31:0] rd_mux;
  logic        rd_hit;

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (addr)
      OFF_PERIPH_ENABLE, OFF_PERIPH_DISABLE: rd_mux = 32'h0000_0000;
      OFF_PERIPH_STATUS:  rd_mux = periph_on_r & periph_mask;
      OFF_MAIN_OSC_CTRL: begin
        rd_mux[POS_OSC_ENABLE]     = main_osc_enable_r;
        rd_mux[POS_OSC_BYPASS]     = osc_bypass_a_r;
        rd_mux[POS_OSC_COUNT +: 8] = osc_startup_count_r;
      end
      OFF_MAIN_CLK_FREQ: begin
        rd_mux[15:0]           = main_freq_count_r;
        rd_mux[POS_FREQ_VALID] = main_freq_valid_r;
      end
      OFF_PLL_CONFIG:     rd_mux = pll_cfg_r;
      OFF_MASTER_CLK_CFG: rd_mux[4:0] = clk_cfg_r[0];
      OFF_PROG_CLK_CFG0:  rd_mux[4:0] = clk_cfg_r[1];
      OFF_PROG_CLK_CFG1:  rd_mux[4:0] = clk_cfg_r[2];
      OFF_PROG_CLK_CFG2:  rd_mux[4:0] = clk_cfg_r[3];
      OFF_CLOCK_STATUS: begin
        rd_mux[POS_SR_OSC_STABLE] = main_osc_stable_r;
        rd_mux[POS_SR_PLL_LOCK]   = pll_lock_r;
        rd_mux[POS_SR_MCK_READY]  = clk_rdy_r[0];
        rd_mux[POS_SR_PCK_READY +: 3] =
          {clk_rdy_r[3], clk_rdy_r[2], clk_rdy_r[1]};
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= apb_req.pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= ~rd_hit;
    end
  end

endmodule : clock_source_and_gating_control

// File: testbench/clock_ctrl_monitor.sv
// Purpose: Port checks of the clock source and gating control.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Bound to the design below the module.
`timescale 1ns/10ps

module clock_ctrl_monitor
  import clock_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic                       clock,
  input wire logic                       rst,
  // Register bus
  input wire apb_req_t                   apb_req,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  // Sources and controls
  input wire logic                       slow_tick,
  input wire logic                       main_tick,
  input wire logic                       pll_tick,
  input wire logic                       osc_enable,
  input wire logic                       osc_bypass,
  input wire pll_ctrl_t                  pll_ctrl,
  // Generated clocks
  input wire logic                       usb_tick,
  input wire logic                       master_tick,
  input wire logic [NUM_PROG_CLOCKS-1:0] prog_tick,
  input wire logic [31:0]                periph_clock_en
);
  // ==========
  // Helpers
  logic        wr_en;
  logic        any_src;
  logic [31:0] wdata;
  assign wr_en   = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign any_src = slow_tick | main_tick | pll_tick;
  assign wdata   = apb_req.pwdata;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_wr(logic [7:0] a);
    wr_en && apb_req.paddr == a;
  endsequence
  // ==========
  // Assertions
  a_low_bits_zero: assert property (periph_clock_en[1:0] == 2'h0)
    else $error("peripheral bits 1:0 set");
  a_disable_stops: assert property (s_wr(OFF_PERIPH_DISABLE) |=>
    (periph_clock_en & $past(wdata)) == 32'h0 &&
    (periph_clock_en & ~$past(wdata)) ==
    ($past(periph_clock_en) & ~$past(wdata)))
    else $error("peripheral disable wrong");
  a_osc_bits_wr: assert property (s_wr(OFF_MAIN_OSC_CTRL) |=>
    {osc_bypass, osc_enable} == $past(wdata[1:0]))
    else $error("oscillator bits wrong");
  a_osc_bits_hold: assert property (
    !(wr_en && apb_req.paddr == OFF_MAIN_OSC_CTRL) |=>
    $stable({osc_bypass, osc_enable}))
    else $error("oscillator bits moved");
  a_pll_mult_wr: assert property (s_wr(OFF_PLL_CONFIG) |=>
    pll_ctrl.pll_multiplier == $past(wdata[26:16]))
    else $error("multiplier wrong");
  a_pll_enable: assert property (s_wr(OFF_PLL_CONFIG) |=>
    pll_ctrl.pll_enable == ($past(wdata[26:16]) != 11'h0))
    else $error("pll enable wrong");
  a_usb_after_pll: assert property (usb_tick |-> $past(pll_tick))
    else $error("usb pulse without pll pulse");
  a_ref_after_main: assert property (
    pll_ctrl.pll_ref_tick |-> $past(main_tick))
    else $error("reference pulse without main pulse");
  a_master_after_src: assert property (
    master_tick |-> $past(any_src))
    else $error("master pulse without source");
  a_prog_after_src: assert property (
    |prog_tick |-> $past(any_src))
    else $error("programmable pulse without source");
  c_disable_wr: cover property (s_wr(OFF_PERIPH_DISABLE));
  c_master_tick: cover property (master_tick);
  c_usb_tick: cover property (usb_tick);
endmodule : clock_ctrl_monitor

bind clock_source_and_gating_control clock_ctrl_monitor i_mon (
  .clock(clock), .rst(rst), .apb_req(apb_req), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .slow_tick(slow_tick),
  .main_tick(main_tick), .pll_tick(pll_tick), .osc_enable(osc_enable),
  .osc_bypass(osc_bypass), .pll_ctrl(pll_ctrl), .usb_tick(usb_tick),
  .master_tick(master_tick), .prog_tick(prog_tick),
  .periph_clock_en(periph_clock_en)
);

// File: testbench/clock_sources_model.sv
// Purpose: Oscillator, slow clock and PLL as source pulses.
// Assumes: Slow period 8 cycles, main period 2, PLL every cycle.
// Notes:   Main pulses fall between slow pulses, never on them.
`timescale 1ns/10ps

module clock_sources_model
  import clock_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic      clock,
  input wire logic      rst,
  // Controls
  input wire logic      osc_enable,
  input wire logic      osc_bypass,
  input wire pll_ctrl_t pll_ctrl,
  // Source pulses
  output logic          slow_tick,
  output logic          main_tick,
  output logic          pll_tick
);
  logic [2:0] phase_r;
  always_ff @(posedge clock) begin
    if (rst) begin
      phase_r <= 3'h0;
    end else begin
      phase_r <= phase_r + 3'h1;
    end
    slow_tick <= (phase_r == 3'h7);
    main_tick <= (osc_enable | osc_bypass) & ~phase_r[0];
    pll_tick  <= pll_ctrl.pll_enable;
  end
endmodule : clock_sources_model

// File: testbench/clock_source_and_gating_control_tb_top.sv
// Purpose: Self-checking bench of the clock source and gating control.
// Assumes: The partner model makes the source pulses.
// Notes:   Fixed seed, so every run repeats.
`timescale 1ns/10ps

module clock_source_and_gating_control_tb_top
  import clock_ctrl_pkg::*;
;
  // ==========
  // Signals
  logic                       clock, rst, pready, pslverr, err;
  logic                       slow_tick, main_tick, pll_tick;
  logic                       osc_enable, osc_bypass, usb_tick, master_tick;
  logic [NUM_PROG_CLOCKS-1:0] prog_tick;
  logic [31:0]                prdata, periph_clock_en, q;
  apb_req_t                   req;
  pll_ctrl_t                  pll_ctrl;
  logic [5:0]                 ticks;
  int                         mismatches, n_checks;
  assign ticks = {prog_tick, master_tick, usb_tick, pll_ctrl.pll_ref_tick};

  clock_source_and_gating_control i_dut (
    .clock(clock), .rst(rst), .apb_req(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .slow_tick(slow_tick),
    .main_tick(main_tick), .pll_tick(pll_tick), .osc_enable(osc_enable),
    .osc_bypass(osc_bypass), .pll_ctrl(pll_ctrl), .usb_tick(usb_tick),
    .master_tick(master_tick), .prog_tick(prog_tick),
    .periph_clock_en(periph_clock_en));
  clock_sources_model i_src (
    .clock(clock), .rst(rst), .osc_enable(osc_enable),
    .osc_bypass(osc_bypass), .pll_ctrl(pll_ctrl), .slow_tick(slow_tick),
    .main_tick(main_tick), .pll_tick(pll_tick));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ==========
  // Tasks
  function automatic int per(input int s);
    return (s == 0) ? 8 : (s == 1) ? 2 : 1;
  endfunction : per
  task automatic chk(input logic [31:0] got, exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock);
    req.penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    q = prdata;
    err = pslverr;
    req <= '0;
    @(posedge clock);
  endtask : apb
  task automatic flag(input int pos, input logic v, input string what);
    apb(1'b0, OFF_CLOCK_STATUS, 32'h0);
    chk({31'h0, q[pos]}, {31'h0, v}, what);
  endtask : flag
  task automatic slow_wait(input int n);
    repeat (n) begin
      @(posedge clock);
      while (slow_tick !== 1'b1) @(posedge clock);
    end
  endtask : slow_wait
  task automatic count(input int sel, input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge clock);
      c += int'(ticks[sel]);
    end
  endtask : count
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (80000) @(posedge clock);
    mismatches++;
    print_verdict();
  end
  // ==========
  // Main sequence
  initial begin
    logic [31:0] cur, e, d, w;
    logic [7:0]  a;
    int          c, s, t;
    rst = 1'b1;
    req = '0;
    mismatches = 0;
    n_checks = 0;
    t = $urandom(32'h6816D70B);
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      a = (i < 2) ? OFF_PERIPH_STATUS + 8'(i * 8)
        : (i == 2) ? OFF_MAIN_CLK_FREQ : (i == 3) ? OFF_PLL_CONFIG
        : (i == 4) ? OFF_MASTER_CLK_CFG : (i == 8) ? OFF_CLOCK_STATUS
        : OFF_PROG_CLK_CFG0 + 8'((i - 5) * 4);
      apb(1'b0, a, 32'h0);
      w = (i == 3) ? RST_PLL_CONFIG : (i == 8) ? 32'h8 : 32'h0;
      chk(q, w, "reset value");
    end
    apb(1'b0, 8'h1C, 32'h0);
    chk({q[31:1], err}, 32'h1, "unmapped access");
    cur = 32'h0;
    for (int i = 0; i < 8; i++) begin
      e = $urandom;
      d = (i == 0) ? 32'h0 : $urandom;
      apb(1'b1, OFF_PERIPH_ENABLE, e);
      apb(1'b1, OFF_PERIPH_DISABLE, d);
      apb(1'b1, OFF_PERIPH_STATUS, 32'hFFFFFFFF);
      cur = (cur | (e & 32'hFFFFFFFC)) & ~d;
      apb(1'b0, OFF_PERIPH_STATUS, 32'h0);
      chk(q, cur, "peripheral status");
      chk(periph_clock_en, cur, "clock enables");
    end
    apb(1'b1, OFF_MAIN_OSC_CTRL, 32'h201);
    flag(POS_SR_OSC_STABLE, 1'b0, "stable early");
    slow_wait(15);
    flag(POS_SR_OSC_STABLE, 1'b0, "stable before count");
    slow_wait(3);
    flag(POS_SR_OSC_STABLE, 1'b1, "stable after count");
    apb(1'b0, OFF_MAIN_CLK_FREQ, 32'h0);
    chk(q & 32'h10000, 32'h0, "frequency not yet valid");
    slow_wait(20);
    apb(1'b0, OFF_MAIN_CLK_FREQ, 32'h0);
    chk(q, 32'h10000 | 32'(FREQ_WINDOW * 8 / 2), "frequency");
    apb(1'b1, OFF_MAIN_OSC_CTRL, 32'h0);
    flag(POS_SR_OSC_STABLE, 1'b0, "stable cleared");
    apb(1'b0, OFF_MAIN_CLK_FREQ, 32'h0);
    chk(q & 32'h10000, 32'h0, "frequency invalid when off");
    apb(1'b1, OFF_MAIN_OSC_CTRL, 32'h2);
    flag(POS_SR_OSC_STABLE, 1'b1, "bypass stable");
    for (int i = 0; i < 3; i++) begin
      e = 32'($urandom_range(2047, 1));
      d = (i == 2) ? 32'h3 : 32'(i);
      w = (32'(i) << POS_USB_RATIO) | (e << POS_PLL_MULT) | 32'h300 | d
        | (32'(i) << POS_PLL_RANGE);
      apb(1'b1, OFF_PLL_CONFIG, w);
      flag(POS_SR_PLL_LOCK, 1'b0, "lock cleared");
      slow_wait(2);
      flag(POS_SR_PLL_LOCK, 1'b0, "lock early");
      slow_wait(2);
      flag(POS_SR_PLL_LOCK, 1'b1, "lock set");
      apb(1'b0, OFF_PLL_CONFIG, 32'h0);
      chk(q, w, "pll readback");
      chk(32'(pll_ctrl.pll_multiplier), e, "multiplier");
      chk(32'(pll_ctrl.pll_range), 32'(i), "range");
      count(0, 96, c);
      chk(32'(c), (d == 0) ? 32'h0 : 32'h30 / d, "reference ticks");
      count(1, 96, c);
      chk(32'(c), 32'(96 >> i), "usb ticks");
    end
    apb(1'b1, OFF_PLL_CONFIG, 32'h301);
    chk({31'h0, pll_ctrl.pll_enable}, 32'h0, "pll off");
    apb(1'b1, OFF_PLL_CONFIG, 32'h10301);
    slow_wait(5);
    flag(POS_SR_PLL_LOCK, 1'b1, "relock");
    for (int ch = 0; ch < 4; ch++) begin
      for (int p = 0; p < 7; p++) begin
        s = (p + 1) % 3;
        a = (ch == 0) ? OFF_MASTER_CLK_CFG : OFF_PROG_CLK_CFG0 + 8'(ch * 4 - 4);
        w = {27'h0, 3'(p), (s == 0) ? SRC_SLOW : (s == 1) ? SRC_MAIN : SRC_PLL};
        apb(1'b1, a, w);
        t = (ch == 0) ? POS_SR_MCK_READY : POS_SR_PCK_READY + ch - 1;
        c = 0;
        apb(1'b0, OFF_CLOCK_STATUS, 32'h0);
        while (q[t] !== 1'b1 && c < 400) begin
          apb(1'b0, OFF_CLOCK_STATUS, 32'h0);
          c++;
        end
        chk({31'h0, q[t]}, 32'h1, "clock ready");
        count(2 + ch, 1024, c);
        chk(32'(c), 32'(1024 / (per(s) << p)), "ticks");
      end
    end
    print_verdict();
  end
endmodule : clock_source_and_gating_control_tb_top
